// ---- logic/spf_baud_gen.sv ----
`timescale 1ns/100ps
module spf_baud_gen (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   spf_link_if.baud  lnk
);
   logic [19:0] cnt_ff;    // Cycle counter
   logic        tick_ff;   // Registered bit pulse

   // ****************************************
   // Bit-rate divider
   // ****************************************
   // Restarts at once if the divisor shrinks below the count
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_ff  <= 20'h00000;
         tick_ff <= 1'b0;
      end else if (cnt_ff >= lnk.bit_div - 20'h00001) begin
         cnt_ff  <= 20'h00000;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff  <= cnt_ff + 20'h00001;
         tick_ff <= 1'b0;
      end
   end

   assign lnk.bit_tick = tick_ff;
endmodule

// ---- logic/spf_consts.svh ----
`ifndef SPF_CONSTS_SVH
`define SPF_CONSTS_SVH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define SPF_IDX_RATE   16'h199C
`define SPF_IDX_DLY    16'h199D
`define SPF_IDX_NODE   16'h199E
`define SPF_IDX_CODE   16'h199F
`define SPF_IDX_CTRL   16'h19A0
`define SPF_IDX_STAT   16'h19A1
// ****************************************
// Field positions and reset values
// ****************************************
`define SPF_LO_LSB     0
`define SPF_HI_LSB     8
`define SPF_SET_LSB    0
`define SPF_MODE_LSB   12
`define SPF_SEN_LSB    8
`define SPF_END_LSB    12
`define SPF_RST_WORD   16'h0000
`define SPF_RATE_MAX   8'h04
`define SPF_FMT_MAX    8'h0B
`define SPF_NODE_MAX   7'h1F
`define SPF_CR         8'h0D
`define SPF_LF         8'h0A
// ****************************************
// Timing
// ****************************************
`define SPF_CLK_HZ     50000000
`define SPF_STEP_MS    10
`define SPF_STEP_CYC   (`SPF_CLK_HZ / 1000 * `SPF_STEP_MS)
`define SPF_BPS0       1200
`define SPF_BPS1       2400
`define SPF_BPS2       4800
`define SPF_BPS3       9600
`define SPF_BPS4       19200
`define SPF_BPS_STD    9600
`endif

// ---- logic/spf_link_if.sv ----
`timescale 1ns/100ps
interface spf_link_if;
   logic [19:0] bit_div;   // Cycles per bit
   logic        bit_tick;  // Bit-rate pulse
   logic [15:0] dly_bcd;   // Delay in BCD steps
   logic        tx_req;    // Send request
   logic        tx_go;     // Delay elapsed pulse
   logic        tx_busy;   // Delay running
   modport ctl  (output bit_div, dly_bcd, tx_req,
                 input  bit_tick, tx_go, tx_busy);
   modport baud (input bit_div, output bit_tick);
   modport dly  (input dly_bcd, tx_req, output tx_go, tx_busy);
endinterface

// ---- logic/spf_pkg.sv ----
package spf_pkg;
   // Receive delimiting state
   typedef enum logic [1:0] {
      RX_IDLE,
      RX_HUNT,
      RX_BODY
   } spf_rx_st_t;

   // End-of-message selection
   typedef enum logic [3:0] {
      END_COUNT,
      END_CHAR,
      END_CRLF
   } spf_end_t;

   // Two BCD digits to binary
   function automatic logic [6:0] bcd2(input logic [7:0] v);
      bcd2 = 7'(v[7:4]) * 7'h0A + 7'(v[3:0]);
   endfunction

   // Four BCD digits to binary
   function automatic logic [13:0] bcd4(input logic [15:0] v);
      bcd4 = 14'(bcd2(v[15:8])) * 14'h0064 + 14'(bcd2(v[7:0]));
   endfunction
endpackage

// ---- logic/spf_top.sv ----
`timescale 1ns/100ps
`include "spf_consts.svh"
// Behaviour
// RL1: Rate codes 0-4 pick 1.2K to 19.2K
// RL2: One start bit; codes 0-5 seven, 6-11 eight
// RL3: Codes 0-2, 6-8 one stop, others two
// RL4: Reset format is 7 data, even, 1 stop; outputs give 7E2 at reset, as settings field resets to 0
// RL5: Parity cycles even, odd, none per triple
// RL6: Send waits BCD count of 10 ms steps
// RL7: Command link node number in BCD 0-31
// RL8: Optional start character opens reception
// RL9: End by count, end character, or CR LF
// RL10: Count code 00 means 256 bytes
// RL11: End character compared from code word
// RL12: Settings field 0 forces 7E2 9600
// RL13: Mode 0 command link, 1 plain serial
// RL14: Setup words act without restart
module spf_top #(
   parameter int P_CLK_HZ   = `SPF_CLK_HZ,
   parameter int P_STEP_CYC = `SPF_STEP_CYC
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [15:0] i_wb_adr,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic [3:0]  i_wb_sel,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_byte,
   input  wire logic        i_tx_req,
   output logic             o_tx_go,
   output logic             o_tx_busy,
   output logic             o_bit_tick,
   output logic             o_data8,
   output logic             o_stop2,
   output logic             o_par_en,
   output logic             o_par_odd,
   output logic             o_cmd_link,
   output logic      [4:0]  o_node_num,
   output logic             o_rx_take,
   output logic      [7:0]  o_rx_data,
   output logic             o_msg_end
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [15:0] rate_ff;     // Rate and frame format word
   logic [15:0] dly_ff;      // Send delay word
   logic [15:0] node_ff;     // Node and delimiter word
   logic [15:0] code_ff;     // Start and end code word
   logic [15:0] ctrl_ff;     // Settings select and mode
   logic        ack_ff;      // Bus answer
   logic [31:0] rdat_ff;     // Read data
   spf_pkg::spf_rx_st_t st_ff;  // Receive state
   spf_pkg::spf_rx_st_t nxt_st; // Next receive state
   logic [8:0]  cnt_ff;      // Bytes in current message
   logic        cr_ff;       // Last byte was CR
   logic        take_ff;     // Byte passed pulse
   logic [7:0]  data_ff;     // Passed byte
   logic        end_ff;      // Message end pulse
   logic        wb_req;      // Request pending
   logic        prog;        // Programmed settings in use
   logic        plain;       // Plain serial mode
   logic [7:0]  fmt;         // Effective format code
   logic        start_en;    // Start character required
   logic [3:0]  end_sel;     // End mode
   logic [8:0]  cnt_tgt;     // Byte count target
   logic        end_hit;     // Current byte ends message
   logic [6:0]  node_bin;    // Node number binary
   spf_link_if lnk ();
   // ****************************************
   // Helpers
   // ****************************************
   // Word index to byte address
   function automatic logic [15:0] adr(input logic [15:0] idx);
      adr = {idx[13:0], 2'b00};
   endfunction
   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] wr16(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
      wr16[7:0]  = s[0] ? d[7:0]  : old[7:0];
      wr16[15:8] = s[1] ? d[15:8] : old[15:8];
   endfunction
   // Rate code to cycles per bit; unknown codes fall to 1.2K
   function automatic logic [19:0] rate_div(input logic [7:0] c);
      case (c)
         8'h01:   rate_div = 20'(P_CLK_HZ / `SPF_BPS1);
         8'h02:   rate_div = 20'(P_CLK_HZ / `SPF_BPS2);
         8'h03:   rate_div = 20'(P_CLK_HZ / `SPF_BPS3);
         8'h04:   rate_div = 20'(P_CLK_HZ / `SPF_BPS4);
         default: rate_div = 20'(P_CLK_HZ / `SPF_BPS0);
      endcase
   endfunction
   // ****************************************
   // Wishbone slave
   // ****************************************
   assign wb_req = i_wb_cyc && i_wb_stb;
   // Answer one cycle after the request, drop after one cycle
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= wb_req && !ack_ff;
      end
   end
   // Write at the acknowledging edge; unmapped writes ignored
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rate_ff <= `SPF_RST_WORD; // RL4
         dly_ff  <= `SPF_RST_WORD;
         node_ff <= `SPF_RST_WORD;
         code_ff <= `SPF_RST_WORD;
         ctrl_ff <= `SPF_RST_WORD;
      end else if (wb_req && ack_ff && i_wb_we) begin
         if (i_wb_adr == adr(`SPF_IDX_RATE)) begin
            rate_ff <= wr16(rate_ff, i_wb_dat, i_wb_sel);
         end else if (i_wb_adr == adr(`SPF_IDX_DLY)) begin
            dly_ff <= wr16(dly_ff, i_wb_dat, i_wb_sel);
         end else if (i_wb_adr == adr(`SPF_IDX_NODE)) begin
            node_ff <= wr16(node_ff, i_wb_dat, i_wb_sel);
         end else if (i_wb_adr == adr(`SPF_IDX_CODE)) begin
            code_ff <= wr16(code_ff, i_wb_dat, i_wb_sel);
         end else if (i_wb_adr == adr(`SPF_IDX_CTRL)) begin
            ctrl_ff <= wr16(ctrl_ff, i_wb_dat, i_wb_sel);
         end
      end
   end
   // Read data captured on the first request cycle
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rdat_ff <= 32'h00000000;
      end else if (wb_req && !ack_ff) begin
         if (i_wb_adr == adr(`SPF_IDX_RATE)) begin
            rdat_ff <= {16'h0000, rate_ff};
         end else if (i_wb_adr == adr(`SPF_IDX_DLY)) begin
            rdat_ff <= {16'h0000, dly_ff};
         end else if (i_wb_adr == adr(`SPF_IDX_NODE)) begin
            rdat_ff <= {16'h0000, node_ff};
         end else if (i_wb_adr == adr(`SPF_IDX_CODE)) begin
            rdat_ff <= {16'h0000, code_ff};
         end else if (i_wb_adr == adr(`SPF_IDX_CTRL)) begin
            rdat_ff <= {16'h0000, ctrl_ff};
         end else if (i_wb_adr == adr(`SPF_IDX_STAT)) begin
            // Live status
            rdat_ff <= {16'h0000, 3'h0, lnk.tx_busy,
                        st_ff == spf_pkg::RX_BODY,
                        st_ff == spf_pkg::RX_HUNT, 1'b0, cnt_ff};
         end else begin
            // Unmapped reads as zero
            rdat_ff <= 32'h00000000;
         end
      end
   end
   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdat_ff;

   // ****************************************
   // Effective line settings
   // ****************************************
   // Decoded every cycle from the live words
   always_comb begin
      prog  = ctrl_ff[`SPF_SET_LSB +: 4] == 4'h1; // RL12 RL14
      plain = ctrl_ff[`SPF_MODE_LSB +: 4] == 4'h1; // RL13
      fmt   = rate_ff[`SPF_HI_LSB +: 8];
      if (fmt > `SPF_FMT_MAX) begin
         fmt = 8'h00;
      end
      if (!prog) begin
         // Standard frame: 7 data, even, 2 stop
         o_data8   = 1'b0; // RL12
         o_stop2   = 1'b1;
         o_par_en  = 1'b1;
         o_par_odd = 1'b0;
         lnk.bit_div = 20'(P_CLK_HZ / `SPF_BPS_STD);
      end else begin
         o_data8   = fmt >= 8'h06; // RL2
         o_stop2   = (fmt >= 8'h03 && fmt <= 8'h05)
                     || fmt >= 8'h09; // RL3
         o_par_en  = (fmt % 8'h03) != 8'h02; // RL5
         o_par_odd = (fmt % 8'h03) == 8'h01; // RL5
         lnk.bit_div = rate_div(rate_ff[`SPF_LO_LSB +: 8]); // RL1
      end
   end
   assign o_bit_tick = lnk.bit_tick;
   assign o_cmd_link = !plain;
   // Node number, out of range reads as zero
   assign node_bin   = spf_pkg::bcd2(node_ff[`SPF_LO_LSB +: 8]);
   assign o_node_num = (node_bin > `SPF_NODE_MAX) ? 5'h00
                       : node_bin[4:0]; // RL7

   // ****************************************
   // Send delay
   // ****************************************
   assign lnk.dly_bcd = dly_ff; // RL6
   assign lnk.tx_req  = i_tx_req;
   assign o_tx_go     = lnk.tx_go;
   assign o_tx_busy   = lnk.tx_busy;
   spf_baud_gen u_baud (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .lnk    (lnk.baud)
   );
   spf_tx_delay #(
      .P_STEP_CYC (P_STEP_CYC)
   ) u_dly (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .lnk    (lnk.dly)
   );

   // ****************************************
   // Receive delimiting
   // ****************************************
   assign start_en = node_ff[`SPF_SEN_LSB +: 4] == 4'h1; // RL8
   assign end_sel  = node_ff[`SPF_END_LSB +: 4];
   // Count code 00 stands for 256
   assign cnt_tgt  = (code_ff[15:8] == 8'h00) ? 9'h100
                     : {1'b0, code_ff[15:8]}; // RL10
   // End detection for the byte now arriving
   always_comb begin
      case (end_sel)
         4'(spf_pkg::END_CHAR):
            end_hit = i_rx_byte == code_ff[15:8]; // RL11
         4'(spf_pkg::END_CRLF):
            end_hit = cr_ff && i_rx_byte == `SPF_LF; // RL9
         default:
            end_hit = cnt_ff + 9'h001 == cnt_tgt; // RL9
      endcase
   end
   // Next state of reception
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         spf_pkg::RX_IDLE: begin
            if (plain) begin
               nxt_st = start_en ? spf_pkg::RX_HUNT : spf_pkg::RX_BODY;
            end
         end
         spf_pkg::RX_HUNT: begin
            if (!plain) begin
               nxt_st = spf_pkg::RX_IDLE; // RL13
            end else if (!start_en
                         || (i_rx_valid && i_rx_byte == code_ff[7:0])) begin
               nxt_st = spf_pkg::RX_BODY; // RL8
            end
         end
         default: begin
            if (!plain) begin
               nxt_st = spf_pkg::RX_IDLE; // RL13
            end else if (i_rx_valid && end_hit) begin
               nxt_st = start_en ? spf_pkg::RX_HUNT : spf_pkg::RX_BODY;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_ff <= spf_pkg::RX_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Byte count and CR memory inside a message
   always_ff @(posedge i_mclk) begin
      if (i_rst || st_ff != spf_pkg::RX_BODY || !plain) begin
         cnt_ff <= 9'h000;
         cr_ff  <= 1'b0;
      end else if (i_rx_valid) begin
         cnt_ff <= end_hit ? 9'h000 : cnt_ff + 9'h001;
         cr_ff  <= !end_hit && i_rx_byte == `SPF_CR;
      end
   end

   // Byte pass-through and end pulse
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         take_ff <= 1'b0;
         data_ff <= 8'h00;
         end_ff  <= 1'b0;
      end else begin
         take_ff <= i_rx_valid && st_ff != spf_pkg::RX_HUNT;
         end_ff  <= i_rx_valid && plain
                    && st_ff == spf_pkg::RX_BODY && end_hit; // RL9
         if (i_rx_valid) begin
            data_ff <= i_rx_byte;
         end
      end
   end

   assign o_rx_take = take_ff;
   assign o_rx_data = data_ff;
   assign o_msg_end = end_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   a_std_frame: assert property (!prog |-> !o_data8 && o_stop2
      && o_par_en && !o_par_odd) else $error("std frame"); // RL12
   a_data_len: assert property (prog && fmt <= `SPF_FMT_MAX
      |-> o_data8 == (fmt >= 8'h06)) else $error("data len"); // RL2
   a_stop_len: assert property (prog && fmt == 8'h08 |-> !o_stop2)
      else $error("stop len"); // RL3
   a_par_none: assert property (prog && fmt == 8'h05 |-> !o_par_en)
      else $error("parity"); // RL5
   a_rate_sel: assert property (prog && rate_ff[7:0] == 8'h04
      |-> lnk.bit_div == 20'(P_CLK_HZ / 19200))
      else $error("rate"); // RL1
   a_zero_dly: assert property (i_tx_req && !o_tx_busy
      && dly_ff == 16'h0000 |=> o_tx_go) else $error("delay"); // RL6
   a_hunt_drop: assert property (st_ff == spf_pkg::RX_HUNT
      && i_rx_valid |=> !o_rx_take) else $error("hunt"); // RL8
   a_count_end: assert property (plain && end_sel == 4'h0
      && code_ff[15:8] == 8'h01 && st_ff == spf_pkg::RX_BODY
      && i_rx_valid |=> o_msg_end) else $error("count"); // RL9
   a_char_end: assert property (plain && end_sel == 4'h1
      && st_ff == spf_pkg::RX_BODY && i_rx_valid
      && i_rx_byte == code_ff[15:8] |=> o_msg_end)
      else $error("end char"); // RL11
   a_cmd_idle: assert property (!plain |=> ##1 st_ff == spf_pkg::RX_IDLE
      || plain || $past(plain)) else $error("mode"); // RL13
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack");

   c_msg_end:  cover property (o_msg_end && end_sel == 4'h2);
   c_hunt_hit: cover property (st_ff == spf_pkg::RX_HUNT
                               ##1 st_ff == spf_pkg::RX_BODY);
   c_tx_wait:  cover property ($fell(o_tx_busy));
endmodule

// ---- logic/spf_tx_delay.sv ----
`timescale 1ns/100ps
`include "spf_consts.svh"
module spf_tx_delay #(
   parameter int P_STEP_CYC = `SPF_STEP_CYC
) (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   spf_link_if.dly   lnk
);
   logic [19:0] cyc_ff;    // Cycles within one step
   logic [13:0] left_ff;   // Steps still to wait
   logic        busy_ff;   // Delay running
   logic        go_ff;     // Send permitted pulse

   // ****************************************
   // Delay countdown
   // ****************************************
   // Requests while busy are ignored; each step is a full period
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cyc_ff  <= 20'h00000;
         left_ff <= 14'h0000;
         busy_ff <= 1'b0;
         go_ff   <= 1'b0;
      end else begin
         go_ff <= 1'b0;
         if (!busy_ff && lnk.tx_req) begin
            // Zero delay sends on the next cycle
            left_ff <= spf_pkg::bcd4(lnk.dly_bcd);
            cyc_ff  <= 20'h00000;
            if (spf_pkg::bcd4(lnk.dly_bcd) == 14'h0000) begin
               go_ff <= 1'b1; // RL6
            end else begin
               busy_ff <= 1'b1;
            end
         end else if (busy_ff) begin
            if (cyc_ff == 20'(P_STEP_CYC - 1)) begin
               cyc_ff  <= 20'h00000;
               left_ff <= left_ff - 14'h0001;
               if (left_ff == 14'h0001) begin
                  busy_ff <= 1'b0;
                  go_ff   <= 1'b1; // RL6
               end
            end else begin
               cyc_ff <= cyc_ff + 20'h00001;
            end
         end
      end
   end

   assign lnk.tx_go   = go_ff;
   assign lnk.tx_busy = busy_ff;
endmodule

// ---- tb/serial_port_frame_config_tb.sv ----
`timescale 1ns/100ps
module serial_port_frame_config_tb;
   // ****************************************
   // Signals
   // ****************************************
   logic        i_mclk = 1'b0;
   logic        rst    = 1'b1;
   logic        cyc    = 1'b0;
   logic        we     = 1'b0;
   logic [15:0] adr    = 16'h0000;
   logic [31:0] dat    = 32'h0000_0000;
   logic [31:0] rdat;
   logic        tx_req = 1'b0;
   logic        rx_valid;
   logic [7:0]  rx_byte;
   logic        go, busy, tick, d8, s2, pe, po, cmd, take, mend, ack;
   logic [4:0]  node;
   logic [7:0]  rdata;
   int          miscompares = 0;
   int          check_count = 0;
   int          cycles      = 0;

   // Clock, 20 ns period
   always #10 i_mclk = ~i_mclk;

   // Clock rate chosen so every bit rate divides exactly
   spf_top #(.P_CLK_HZ(384000), .P_STEP_CYC(10)) dut (
      .i_mclk, .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat),
      .i_wb_sel(4'h3), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_tx_req(tx_req),
      .o_tx_go(go), .o_tx_busy(busy), .o_bit_tick(tick),
      .o_data8(d8), .o_stop2(s2), .o_par_en(pe), .o_par_odd(po),
      .o_cmd_link(cmd), .o_node_num(node), .o_rx_take(take),
      .o_rx_data(rdata), .o_msg_end(mend));

   spf_host_model host (.i_mclk, .o_rx_valid(rx_valid),
                        .o_rx_byte(rx_byte));

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Hang guard
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         report_and_stop;
      end
   end

   // ****************************************
   // Bus and stimulus tasks
   // ****************************************
   task automatic wb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge i_mclk);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      chk({31'h0, ack}, 32'h1);
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, {16'h0, d}, q);
      // Let the written word settle before outputs are looked at
      #1;
   endtask

   task automatic rdc(input logic [15:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   // Frame shape outputs
   task automatic fmt(input logic [3:0] e);
      chk({28'h0, d8, s2, pe, po}, {28'h0, e});
   endtask

   // Period between two bit ticks
   task automatic meas(input int e);
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(posedge i_mclk);
            n++;
         end while (tick !== 1'b1);
      end
      chk(32'(n), 32'(e));
   endtask

   // Send request, count cycles to the go pulse
   task automatic tx(input int e);
      int n;
      @(posedge i_mclk);
      tx_req <= 1'b1;
      @(posedge i_mclk);
      tx_req <= 1'b0;
      #1;
      n = 0;
      while (go !== 1'b1) begin
         if (n == e / 2)
            chk({31'h0, busy}, 32'h1);
         @(posedge i_mclk);
         #1;
         n++;
      end
      chk(32'(n), 32'(e));
      @(posedge i_mclk);
      #1;
      chk({30'h0, go, busy}, 32'h0);
   endtask

   // One received byte and its expected result
   task automatic rx(input logic [7:0] b, input logic t, input logic e);
      host.send(b, 1);
      #1;
      chk({30'h0, take, mend}, {30'h0, t, e});
      if (t)
         chk({24'h0, rdata}, {24'h0, b});
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge i_mclk);
      rst <= 1'b0;
      // Reset values and standard frame
      rdc(16'h6670, 32'h0);
      rdc(16'h6674, 32'h0);
      rdc(16'h6678, 32'h0);
      rdc(16'h667C, 32'h0);
      rdc(16'h6680, 32'h0);
      fmt(4'b0110);
      chk({26'h0, cmd, node}, {26'h0, 1'b1, 5'h00});
      meas(40);
      $display("test reset done");
      // Every frame code while running
      wr(16'h6680, 16'h0001);
      for (int c = 0; c < 12; c++) begin
         wr(16'h6670, {8'(c), 8'h00});
         fmt({c >= 6, (c % 6) >= 3, (c % 3) != 2, (c % 3) == 1});
      end
      $display("test format done");
      for (int r = 0; r < 5; r++) begin
         wr(16'h6670, {8'h00, 8'(r)});
         meas(320 >> r);
      end
      $display("test rate done");
      // Readback and an unmapped place
      wr(16'h6670, 16'h0B04);
      rdc(16'h6670, 32'h0000_0B04);
      wr(16'h6690, 16'hFFFF);
      rdc(16'h6690, 32'h0);
      wr(16'h6678, 16'h0031);
      chk({27'h0, node}, 32'd31);
      wr(16'h6678, 16'h0012);
      chk({27'h0, node}, 32'd12);
      $display("test registers done");
      // Send delay, zero and twelve steps
      tx(0);
      wr(16'h6674, 16'h0012);
      tx(120);
      $display("test delay done");
      // Plain serial with start char and count 3
      wr(16'h6678, 16'h0100);
      wr(16'h667C, 16'h0302);
      wr(16'h6680, 16'h1001);
      chk({31'h0, cmd}, 32'h0);
      rdc(16'h6684, 32'h0000_0400);
      rx(8'h41, 1'b0, 1'b0);
      rx(8'h02, 1'b0, 1'b0);
      rx(8'h10, 1'b1, 1'b0);
      rx(8'h11, 1'b1, 1'b0);
      rx(8'h12, 1'b1, 1'b1);
      // Count code 00
      wr(16'h6678, 16'h0000);
      wr(16'h667C, 16'h0000);
      for (int i = 0; i < 256; i++)
         rx(8'(i), 1'b1, i == 255);
      // End character
      wr(16'h6678, 16'h1000);
      wr(16'h667C, 16'h2E00);
      rx(8'h41, 1'b1, 1'b0);
      rx(8'h2E, 1'b1, 1'b1);
      // CR then LF only
      wr(16'h6678, 16'h2000);
      rx(8'h0D, 1'b1, 1'b0);
      rx(8'h41, 1'b1, 1'b0);
      rx(8'h0A, 1'b1, 1'b0);
      rx(8'h0D, 1'b1, 1'b0);
      rx(8'h0A, 1'b1, 1'b1);
      // Command link ignores delimiters
      wr(16'h6680, 16'h0001);
      rx(8'h0A, 1'b1, 1'b0);
      rx(8'h2E, 1'b1, 1'b0);
      $display("test receive done");
      report_and_stop;
   end
endmodule

// ---- tb/spf_host_model.sv ----
`timescale 1ns/100ps
// ****************************************
// Remote host: delivers received bytes
// ****************************************
module spf_host_model (
   input  wire logic       i_mclk,
   output logic            o_rx_valid,
   output logic [7:0]      o_rx_byte
);
   // Idle line at time zero
   initial begin
      o_rx_valid = 1'b0;
      o_rx_byte  = 8'h00;
   end

   // One byte per valid pulse; gap cycles model a slow host
   task automatic send(input logic [7:0] b, input int gap);
      repeat (gap) @(posedge i_mclk);
      @(posedge i_mclk);
      o_rx_valid <= 1'b1;
      o_rx_byte  <= b;
      @(posedge i_mclk);
      o_rx_valid <= 1'b0;
      // Stale data never looks like the last byte
      o_rx_byte  <= ~b;
   endtask
endmodule
